/* File: bench/serial_far_end.sv */
// far-end serial source model: eight-phase samples of a looped bit stream
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
    input wire logic clk_i,             // serial-rate clock
    input wire logic bit_i,             // bit being sent
    input wire logic [2:0] edge_pos_i,  // phase at which the bit changes
    output logic [7:0] samples_o        // line seen on eight phases
);
    logic prev_r = 1'b0;
    always_ff @(posedge clk_i)
    begin
        prev_r <= bit_i;
    end
    // phases ahead of the edge still see the old bit, so skew is real
    always_comb
    begin
        for (int k = 0; k < 8; k++)
        begin
            samples_o[k] = (k < int'(edge_pos_i)) ? prev_r : bit_i;
        end
    end
endmodule : serial_far_end
`default_nettype wire

/* File: bench/tb_diff_serdes_with_phase_align.sv */
// self-checking bench for one serdes channel looped back on itself
`timescale 1ns/1ps
`default_nettype none
module tb_diff_serdes_with_phase_align;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, tx_load_o, tx_serial_o, rx_word_valid_o, settled, roll;
    logic freeze = 1'b0, clear = 1'b0, slip = 1'b0, use_dpa = 1'b1, rclr = 1'b0;
    logic [2:0] edge_pos = 3'h2;
    logic [2:0] step;
    logic [7:0] samples;
    logic [9:0] rx_word_o, w0;
    int n_errors = 0;
    int check_count = 0;
    diff_serdes_with_phase_align diff_serdes_with_phase_align_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_word_i(10'h00A), .tx_load_o(tx_load_o), .tx_bypass_data_i(2'h1),
        .tx_serial_o(tx_serial_o), .tx_phase_step_o(step), .rx_phase_samples_i(samples),
        .phase_aligner_use_i(use_dpa), .phase_select_freeze_i(freeze),
        .phase_aligner_clear_i(clear), .resync_buffer_clear_i(rclr),
        .word_slip_request_i(slip), .rx_word_o(rx_word_o), .rx_word_valid_o(rx_word_valid_o),
        .phase_settled_flag_o(settled), .slip_rollover_flag_o(roll));
    serial_far_end serial_far_end_i (.clk_i(clk_i), .bit_i(tx_serial_o),
        .edge_pos_i(edge_pos), .samples_o(samples));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        check(n < 20, 1);
    endtask : wb
    task automatic wait_valid;
        for (int n = 0; n < 40 && rx_word_valid_o !== 1'b1; n++)
            @(negedge clk_i);
    endtask : wait_valid
    task automatic wait_settled;
        for (int n = 0; n < 3000 && settled !== 1'b1; n++)
            @(negedge clk_i);
        check(settled, 1);
    endtask : wait_settled
    // slip pulse held and spaced well over one parallel period
    task automatic slip_once(input logic [3:0] cnt, input logic [9:0] word);
        @(posedge clk_i);
        slip <= 1'b1;
        @(posedge clk_i);
        // first word after the edge may be mixed; the second must be clean
        @(negedge clk_i);
        wait_valid();
        @(negedge clk_i);
        wait_valid();
        check(rx_word_o, word);
        repeat (8) @(posedge clk_i);
        slip <= 1'b0;
        repeat (8) @(posedge clk_i);
        wb(1'b0, serdes_pkg::STAT_ADDR, 32'h0000_0000);
        check(rd[8:4], {cnt == 4'h1, cnt});
        check(roll, cnt == 4'h1);
    endtask : slip_once
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        wb(1'b0, serdes_pkg::CTRL_ADDR, 32'h0000_0000);
        check(rd, {10'h000, serdes_pkg::CTRL_RST});
        wb(1'b0, serdes_pkg::ROLL_ADDR, 32'h0000_0000);
        check(rd, {28'h000_0000, serdes_pkg::ROLL_RST});
        wb(1'b1, 4'hC, 32'hFFFF_FFFF);
        wb(1'b0, 4'hC, 32'h0000_0000);
        check(rd, 0);
    endtask : t_regs
    task automatic tx_four(input logic [31:0] ctrl, input logic [3:0] exp);
        wb(1'b1, serdes_pkg::CTRL_ADDR, ctrl);
        repeat (20) @(negedge clk_i);
        for (int n = 0; n < 20 && tx_load_o !== 1'b1; n++)
            @(negedge clk_i);
        // line register adds one cycle after the load edge
        @(negedge clk_i);
        for (int i = 3; i >= 0; i--)
        begin
            @(negedge clk_i);
            check(tx_serial_o, exp[i]);
            if (i == 1)
                check(tx_load_o, 1);
        end
    endtask : tx_four
    task automatic t_tx;
        tx_four(32'h0010_0044, 4'hA);
    endtask : t_tx
    task automatic t_modes;
        logic b;
        tx_four(32'h0010_1144, 4'h5);
        tx_four(32'h0010_0344, 4'hC);
        wb(1'b1, serdes_pkg::CTRL_ADDR, 32'h0011_0044);
        repeat (3) @(negedge clk_i);
        check({tx_load_o, tx_serial_o}, 2'b01);
        wb(1'b1, serdes_pkg::CTRL_ADDR, 32'h0017_A044);
        repeat (3) @(negedge clk_i);
        b = tx_serial_o;
        @(negedge clk_i);
        check({step, tx_serial_o}, {3'h5, !b});
        check({settled, rx_word_valid_o}, 2'b01);
        wb(1'b1, serdes_pkg::CTRL_ADDR, 32'h0010_0044);
        wait_settled();
        @(posedge clk_i);
        use_dpa <= 1'b0;
        repeat (3) @(posedge clk_i);
        check(settled, 0);
        use_dpa <= 1'b1;
    endtask : t_modes
    task automatic t_rx;
        int gap;
        wb(1'b1, serdes_pkg::ROLL_ADDR, 32'h0000_0001);
        wait_settled();
        @(negedge clk_i);
        wait_valid();
        @(negedge clk_i);
        gap = 1;
        for (int n = 0; n < 20 && rx_word_valid_o !== 1'b1; n++)
        begin
            @(negedge clk_i);
            gap++;
        end
        check(gap, 4);
        w0 = rx_word_o;
        slip_once(4'h1, {6'h00, ~w0[3:0]});
        slip_once(4'h0, w0);
    endtask : t_rx
    task automatic t_track;
        logic [2:0] p0;
        logic drop;
        freeze <= 1'b1;
        wb(1'b0, serdes_pkg::STAT_ADDR, 32'h0000_0000);
        p0 = rd[2:0];
        edge_pos <= edge_pos + 3'h3;
        repeat (60) @(posedge clk_i);
        wb(1'b0, serdes_pkg::STAT_ADDR, 32'h0000_0000);
        check(rd[3:0], {1'b1, p0});
        freeze <= 1'b0;
        repeat (200) @(posedge clk_i);
        wb(1'b0, serdes_pkg::STAT_ADDR, 32'h0000_0000);
        check(rd[3:0], {1'b1, 3'(edge_pos + 3'h4)});
        clear <= 1'b1;
        rclr <= 1'b1;
        repeat (2) @(posedge clk_i);
        clear <= 1'b0;
        rclr <= 1'b0;
        @(negedge clk_i);
        check(settled, 0);
        wait_settled();
        // second settle option: one lone move keeps the flag
        wb(1'b1, serdes_pkg::CTRL_ADDR, 32'h0030_0044);
        edge_pos <= edge_pos + 3'h2;
        drop = 1'b0;
        for (int n = 0; n < 40; n++)
        begin
            @(negedge clk_i);
            drop = drop | !settled;
        end
        wb(1'b0, serdes_pkg::STAT_ADDR, 32'h0000_0000);
        check({drop, rd[3:0]}, {2'b01, 3'(edge_pos + 3'h4)});
    endtask : t_track
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        final_report();
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_tx();
        t_modes();
        t_rx();
        t_track();
        final_report();
    end
endmodule : tb_diff_serdes_with_phase_align
`default_nettype wire

/* File: rtl/diff_serdes_with_phase_align.sv */
// one serdes channel: serializer, forwarded clock, phase aligner, deserializer
`timescale 1ns/1ps
`default_nettype none
module diff_serdes_with_phase_align (
    input wire logic clk_i,                   // serial-rate clock
    input wire logic rst_i,                   // synchronous reset, high
    input wire logic wb_cyc_i,                // wishbone cycle
    input wire logic wb_stb_i,                // wishbone strobe
    input wire logic wb_we_i,                 // wishbone write
    input wire logic [3:0] wb_adr_i,          // wishbone byte address
    input wire logic [3:0] wb_sel_i,          // wishbone byte enables
    input wire logic [31:0] wb_dat_i,         // wishbone write data
    output logic [31:0] wb_dat_o,             // wishbone read data
    output logic wb_ack_o,                    // wishbone acknowledge
    input wire logic [9:0] tx_word_i,         // parallel transmit word
    output logic tx_load_o,                   // word taken this cycle
    input wire logic [1:0] tx_bypass_data_i,  // bypass register data
    output logic tx_serial_o,                 // serial line out
    output logic [2:0] tx_phase_step_o,       // extra 45 degree steps to pll
    input wire logic [7:0] rx_phase_samples_i,// line sampled on eight phases
    input wire logic phase_aligner_use_i,     // dynamic aligner enable
    input wire logic phase_select_freeze_i,   // hold current phase
    input wire logic phase_aligner_clear_i,   // reset aligner
    input wire logic resync_buffer_clear_i,   // reset resync buffer
    input wire logic word_slip_request_i,     // one-bit slip request
    output logic [9:0] rx_word_o,             // parallel receive word
    output logic rx_word_valid_o,             // word strobe
    output logic phase_settled_flag_o,        // aligner locked
    output logic slip_rollover_flag_o         // slip at rollover point
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] clamp_factor(input logic [3:0] f);
        logic [3:0] r;
        r = f;
        if (f < serdes_pkg::FACTOR_MIN)
            r = serdes_pkg::FACTOR_MIN;
        else if (f > serdes_pkg::FACTOR_MAX)
            r = serdes_pkg::FACTOR_MAX;
        return r;
    endfunction : clamp_factor

    // first edge in the eight samples; centre lies four phases later
    function automatic logic [2:0] best_phase(input logic [7:0] s, input logic [2:0] cur);
        logic [2:0] r;
        logic found;
        r = cur;
        found = 1'b0;
        for (int i = 1; i < serdes_pkg::PHASES; i++)
        begin
            if (!found && (s[i] != s[i-1]))
            begin
                r = 3'(i + 4);
                found = 1'b1;
            end
        end
        return r;
    endfunction : best_phase

    // ------------------------------------------------------------
    // wishbone registers
    // ------------------------------------------------------------
    logic [21:0] ctrl_r;
    logic [3:0] roll_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic [31:0] wmask;
    logic req;
    logic [2:0] phase_r;
    logic settled_r;
    logic [3:0] slip_cnt_r;

    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= serdes_pkg::CTRL_RST;
            roll_r <= serdes_pkg::ROLL_RST;
        end
        else if (req && wb_we_i)
        begin
            if (wb_adr_i == serdes_pkg::CTRL_ADDR)
                ctrl_r <= (ctrl_r & ~wmask[21:0]) | (wb_dat_i[21:0] & wmask[21:0]);
            else if (wb_adr_i == serdes_pkg::ROLL_ADDR && wb_sel_i[0])
                roll_r <= wb_dat_i[3:0];
        end
    end

    always_comb
    begin
        rdat_nxt = 32'h0000_0000;
        case (wb_adr_i)
            serdes_pkg::CTRL_ADDR: rdat_nxt[21:0] = ctrl_r;
            serdes_pkg::ROLL_ADDR: rdat_nxt[3:0] = roll_r;
            serdes_pkg::STAT_ADDR:
            begin
                rdat_nxt[serdes_pkg::STAT_PHASE_POS +: 3] = phase_r;
                rdat_nxt[serdes_pkg::STAT_SETTLED_POS] = settled_r;
                rdat_nxt[serdes_pkg::STAT_SLIP_POS +: 4] = slip_cnt_r;
                rdat_nxt[serdes_pkg::STAT_ROLL_POS] = slip_rollover_flag_o;
            end
            default: rdat_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req;
            rdat_r <= rdat_nxt;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ------------------------------------------------------------
    // static configuration fields
    // ------------------------------------------------------------
    logic [3:0] tx_factor;
    logic [3:0] rx_factor;
    logic [2:0] clk_div_code;
    logic clk_mode;
    logic tx_bypass;
    logic tx_ddr;
    logic rx_bypass;
    logic rx_ddr;
    logic align_on;
    logic settle_mode;
    logic [3:0] roll_pt;

    assign tx_factor = clamp_factor(ctrl_r[serdes_pkg::TX_FACTOR_POS +: 4]);
    assign rx_factor = clamp_factor(ctrl_r[serdes_pkg::RX_FACTOR_POS +: 4]);
    assign clk_mode = ctrl_r[serdes_pkg::TX_CLKMODE_POS];
    assign clk_div_code = ctrl_r[serdes_pkg::TX_CLKDIV_POS +: 3];
    assign tx_bypass = ctrl_r[serdes_pkg::TX_BYPASS_POS];
    assign tx_ddr = ctrl_r[serdes_pkg::TX_DDR_POS];
    assign rx_bypass = ctrl_r[serdes_pkg::RX_BYPASS_POS];
    assign rx_ddr = ctrl_r[serdes_pkg::RX_DDR_POS];
    // aligner dead when deserializer is bypassed
    assign align_on = ctrl_r[serdes_pkg::ALIGN_EN_POS] && phase_aligner_use_i && !rx_bypass;
    assign settle_mode = ctrl_r[serdes_pkg::SETTLE_MODE_POS];
    assign roll_pt = (roll_r < serdes_pkg::ROLL_MIN) ? serdes_pkg::ROLL_MIN :
                     (roll_r > serdes_pkg::ROLL_MAX) ? serdes_pkg::ROLL_MAX : roll_r;
    assign tx_phase_step_o = ctrl_r[serdes_pkg::TX_STEP_POS +: 3];

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    logic [3:0] tx_cnt_r;
    logic [9:0] tx_shift_r;
    logic [3:0] div_bits;
    logic [3:0] ck_cnt_r;
    logic ck_r;
    logic tx_line_nxt;

    // load pulse derived from the factor counter
    assign tx_load_o = (tx_cnt_r == 4'h0) && !tx_bypass;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_cnt_r <= 4'h0;
            tx_shift_r <= 10'h000;
        end
        else if (tx_load_o)
        begin
            tx_cnt_r <= tx_factor - 4'h1;
            // left justify so bit 9 always leaves first
            tx_shift_r <= 10'(tx_word_i << (4'hA - tx_factor));
        end
        else
        begin
            tx_cnt_r <= (tx_cnt_r == 4'h0) ? 4'h0 : tx_cnt_r - 4'h1;
            tx_shift_r <= {tx_shift_r[8:0], 1'b0};
        end
    end

    // divisor legal only where it fits the factor, else data rate
    always_comb
    begin
        div_bits = 4'h1;
        case (clk_div_code)
            3'h1: div_bits = tx_factor[0] ? 4'h1 : 4'h2;
            3'h2: div_bits = (tx_factor == 4'h4 || tx_factor == 4'h8) ? 4'h4 : 4'h1;
            3'h3: div_bits = (tx_factor == 4'h8) ? 4'h8 : 4'h1;
            3'h4: div_bits = (tx_factor == 4'hA) ? 4'hA : 4'h1;
            default: div_bits = 4'h1;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ck_cnt_r <= 4'h0;
            ck_r <= 1'b0;
        end
        else if (tx_load_o || ck_cnt_r >= div_bits - 4'h1)
        begin
            // restart on each load keeps clock framed to the word
            ck_cnt_r <= 4'h0;
            ck_r <= tx_load_o ? 1'b1 : !ck_r;
        end
        else
            ck_cnt_r <= ck_cnt_r + 4'h1;
    end

    always_comb
    begin
        if (tx_bypass)
            tx_line_nxt = (tx_ddr && ck_r) ? tx_bypass_data_i[1] : tx_bypass_data_i[0];
        else if (clk_mode)
            tx_line_nxt = ck_r ^ ctrl_r[serdes_pkg::TX_CLKINV_POS];
        else
            tx_line_nxt = tx_shift_r[9];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tx_serial_o <= 1'b0;
        else
            tx_serial_o <= tx_line_nxt;
    end

    // ------------------------------------------------------------
    // phase aligner
    // ------------------------------------------------------------
    logic [7:0] smp_a_r;
    logic [7:0] smp_b_r;
    logic [2:0] want;
    logic [3:0] run_r;
    logic last_dir_r;
    logic moved_r;
    logic ever_lock_r;
    logic first_lock;
    logic move;
    logic move_dir;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            smp_a_r <= 8'h00;
            smp_b_r <= 8'h00;
        end
        else
        begin
            smp_a_r <= rx_phase_samples_i;
            smp_b_r <= smp_a_r;
        end
    end

    assign want = best_phase(smp_b_r, phase_r);
    assign move = align_on && !phase_select_freeze_i && (want != phase_r);
    assign move_dir = 3'(want - phase_r) < 3'h4;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || phase_aligner_clear_i)
        begin
            phase_r <= 3'h0;
            run_r <= 4'h0;
            settled_r <= 1'b0;
            last_dir_r <= 1'b0;
            moved_r <= 1'b0;
        end
        else if (!align_on)
        begin
            phase_r <= 3'h0;
            run_r <= 4'h0;
            settled_r <= 1'b0;
            moved_r <= 1'b0;
        end
        else if (move)
        begin
            phase_r <= want;
            run_r <= 4'h0;
            last_dir_r <= move_dir;
            moved_r <= 1'b1;
            // mode 0 drops on any move, mode 1 on second move same way
            if (!settle_mode || (moved_r && last_dir_r == move_dir))
                settled_r <= 1'b0;
        end
        else if (run_r == serdes_pkg::SETTLE_RUN)
        begin
            settled_r <= 1'b1;
            moved_r <= 1'b0;
        end
        else
            run_r <= run_r + 4'h1;
    end
    assign phase_settled_flag_o = settled_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || phase_aligner_clear_i)
            ever_lock_r <= 1'b0;
        else if (settled_r)
            ever_lock_r <= 1'b1;
    end
    assign first_lock = settled_r && !ever_lock_r;

    // ------------------------------------------------------------
    // resync buffer
    // ------------------------------------------------------------
    logic [5:0] rsb_r;
    logic [2:0] wptr_r;
    logic [2:0] rptr_r;
    logic rsb_out;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || resync_buffer_clear_i || first_lock)
        begin
            wptr_r <= serdes_pkg::RESYNC_HALF;
            rptr_r <= 3'h0;
            rsb_r <= 6'h00;
        end
        else
        begin
            rsb_r[wptr_r] <= smp_b_r[phase_r];
            wptr_r <= (wptr_r == serdes_pkg::RESYNC_LAST) ? 3'h0 : wptr_r + 3'h1;
            rptr_r <= (rptr_r == serdes_pkg::RESYNC_LAST) ? 3'h0 : rptr_r + 3'h1;
        end
    end
    assign rsb_out = rsb_r[rptr_r];

    // ------------------------------------------------------------
    // word slip
    // ------------------------------------------------------------
    logic [11:0] hist_r;
    logic slip_d_r;
    logic slip_rise;
    logic slip_bit;

    // request comes from fabric on this clock, so no synchroniser
    assign slip_rise = word_slip_request_i && !slip_d_r && !rx_bypass;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slip_d_r <= 1'b0;
            slip_cnt_r <= 4'h0;
            hist_r <= 12'h000;
        end
        else
        begin
            slip_d_r <= word_slip_request_i;
            hist_r <= {hist_r[10:0], rsb_out};
            if (slip_rise)
                slip_cnt_r <= (slip_cnt_r >= roll_pt) ? 4'h0 : slip_cnt_r + 4'h1;
        end
    end
    assign slip_bit = hist_r[slip_cnt_r];
    assign slip_rollover_flag_o = (slip_cnt_r == roll_pt);

    // ------------------------------------------------------------
    // deserializer
    // ------------------------------------------------------------
    logic [3:0] rx_cnt_r;
    logic [9:0] rx_shift_r;
    logic rx_in;

    assign rx_in = rx_bypass ? smp_b_r[0] : slip_bit;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_cnt_r <= 4'h0;
            rx_shift_r <= 10'h000;
            rx_word_o <= 10'h000;
            rx_word_valid_o <= 1'b0;
        end
        else if (rx_bypass)
        begin
            // input registers: single bit, or pair in double rate
            rx_shift_r <= {rx_shift_r[8:0], rx_in};
            rx_word_o <= rx_ddr ? {8'h00, rx_shift_r[0], rx_in} : {9'h000, rx_in};
            rx_word_valid_o <= 1'b1;
        end
        else
        begin
            rx_shift_r <= {rx_shift_r[8:0], rx_in};
            rx_word_valid_o <= (rx_cnt_r == rx_factor - 4'h1);
            if (rx_cnt_r == rx_factor - 4'h1)
            begin
                rx_cnt_r <= 4'h0;
                // first bit received lands in the word's top bit
                rx_word_o <= 10'({rx_shift_r[8:0], rx_in} & ((10'h001 << rx_factor) - 10'h001));
            end
            else
                rx_cnt_r <= rx_cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence slip_edge_s;
        word_slip_request_i && !slip_d_r && !rx_bypass && slip_cnt_r < roll_pt;
    endsequence

    chk_slip_count_step: assert property (slip_edge_s |=> slip_cnt_r == $past(slip_cnt_r) + 4'h1)
        else $error("slip did not add one bit");
    chk_slip_roll_wrap: assert property (word_slip_request_i && !slip_d_r && !rx_bypass
        && slip_cnt_r >= roll_pt |=> slip_cnt_r == 4'h0)
        else $error("slip count did not roll over");
    chk_roll_flag_level: assert property (slip_edge_s && slip_cnt_r == roll_pt - 4'h1
        |=> slip_rollover_flag_o)
        else $error("rollover flag missed the preset point");
    chk_tx_msb_first: assert property (tx_load_o && !clk_mode && !tx_bypass && !rst_i
        ##1 !rst_i |=> tx_serial_o == $past(tx_word_i[tx_factor - 4'h1], 2))
        else $error("first serial bit is not the msb");
    chk_tx_load_period: assert property (tx_load_o && $stable(ctrl_r) |-> ##1 !tx_load_o)
        else $error("load pulse lasted more than one cycle");
    chk_freeze_holds: assert property (phase_select_freeze_i && align_on
        && !phase_aligner_clear_i |=> $stable(phase_r))
        else $error("phase moved while frozen");
    chk_clear_aligner: assert property (phase_aligner_clear_i |=> !settled_r && phase_r == 3'h0)
        else $error("aligner clear did not reset");
    chk_move_drops_lock: assert property (move && !settle_mode && !phase_aligner_clear_i |=> !settled_r)
        else $error("settled flag held across phase change");
    chk_resync_gap: assert property (3'(wptr_r + 3'h6 - rptr_r) == serdes_pkg::RESYNC_HALF
        || 3'(wptr_r - rptr_r) == serdes_pkg::RESYNC_HALF)
        else $error("resync pointers lost their spacing");
    chk_bypass_no_align: assert property (rx_bypass |=> !settled_r)
        else $error("aligner active with deserializer bypassed");
endmodule : diff_serdes_with_phase_align
`default_nettype wire

/* File: rtl/serdes_pkg.sv */
// constants shared by the differential serdes block
package serdes_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] ROLL_ADDR = 4'h4;
    localparam logic [3:0] STAT_ADDR = 4'h8;
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int TX_FACTOR_POS = 0;
    localparam int RX_FACTOR_POS = 4;
    localparam int TX_CLKMODE_POS = 8;
    localparam int TX_CLKDIV_POS = 9;
    localparam int TX_CLKINV_POS = 12;
    localparam int TX_STEP_POS = 13;
    localparam int TX_BYPASS_POS = 16;
    localparam int TX_DDR_POS = 17;
    localparam int RX_BYPASS_POS = 18;
    localparam int RX_DDR_POS = 19;
    localparam int ALIGN_EN_POS = 20;
    localparam int SETTLE_MODE_POS = 21;
    localparam int CTRL_BITS = 22;
    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int STAT_PHASE_POS = 0;
    localparam int STAT_SETTLED_POS = 3;
    localparam int STAT_SLIP_POS = 4;
    localparam int STAT_ROLL_POS = 8;
    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [21:0] CTRL_RST = 22'h10_00AA;
    localparam logic [3:0] ROLL_RST = 4'hA;
    localparam logic [3:0] FACTOR_MIN = 4'h4;
    localparam logic [3:0] FACTOR_MAX = 4'hA;
    localparam logic [3:0] ROLL_MIN = 4'h1;
    localparam logic [3:0] ROLL_MAX = 4'hB;
    localparam int WORD_W = 10;
    localparam int PHASES = 8;
    localparam int RESYNC_DEPTH = 6;
    localparam logic [2:0] RESYNC_HALF = 3'h3;
    localparam logic [2:0] RESYNC_LAST = 3'h5;
    localparam int SLIP_HIST = 12;
    localparam logic [3:0] SETTLE_RUN = 4'h8;
    // training length the far end must send before lock is trusted
    localparam int TRAIN_REPEAT = 256;
    // forwarded clock ceiling and serial rate of clk_i
    localparam int FWD_CLK_MAX_MHZ = 717;
    localparam int CLK_MHZ = 200;
endpackage : serdes_pkg
